// ==== logic/adc_ctl_cfg.svh ====
/*
  constants for the converter control block: register offsets, field positions,
  reset values and timing counts.
  assumes: included by bare name from the package and the design file.
*/
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH
// register offsets
`define ADC_OFS_CSR 2'h0
`define ADC_OFS_DRH 2'h1
`define ADC_OFS_DRL 2'h2
// control/status field positions
`define ADC_BIT_DONE 7
`define ADC_BIT_SPEED 6
`define ADC_BIT_ON 5
`define ADC_CH_MSB 3
// reset values
`define ADC_CSR_RST 8'h00
`define ADC_RES_RST 10'h000
// result saturation codes
`define ADC_RES_FULL 10'h3ff
`define ADC_RES_ZERO 10'h000
// converter clock dividers
`define ADC_DIV_SLOW 3'h4
`define ADC_DIV_FAST 3'h2
// converter clocks per conversion
`define ADC_CONV_CLKS 5'h0e
`endif

// ==== logic/adc_ctl_pkg.sv ====
/*
  types for the converter control block.
  assumes: the cfg header sits on the include path.
*/
package adc_ctl_pkg;
  `include "adc_ctl_cfg.svh"
  // conversion sequencer states
  typedef enum logic [1:0] {ST_OFF, ST_HALTED, ST_CONV} conv_state_t;
  // register address type
  typedef logic [1:0] reg_addr_t;
endpackage : adc_ctl_pkg

// ==== logic/adc_conversion_control.sv ====
/*
  control logic for a ten-bit successive approximation converter: control and
  status register, result pair, clock divider and conversion sequencer.
  assumes: the analog side presents a ten-bit sample and range flags for the
  selected input, synchronous to i_sys_clk; register port has no wait states.
*/
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_cfg.svh"
module adc_conversion_control (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // register port
  input wire adc_ctl_pkg::reg_addr_t i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // processor power modes
  input wire logic i_halt_mode,
  input wire logic i_wait_mode,
  // analog side
  input wire logic [9:0] i_sample,
  input wire logic i_over_range,
  input wire logic i_under_range,
  output logic [3:0] o_channel_select,
  output logic o_converter_on,
  output logic o_sample_strobe
);
  import adc_ctl_pkg::*;

  // control fields
  logic speed_ff; // converter clock speed select
  logic converter_on_ff; // converter enable
  logic [3:0] channel_select_ff; // selected analog input
  logic done_ff; // conversion complete flag
  logic [9:0] result_ff; // last conversion result
  logic [2:0] div_cnt_ff; // divider for converter clock
  logic [4:0] conv_cnt_ff; // converter clocks into this conversion
  conv_state_t state_ff; // sequencer state
  logic [7:0] rdata_ff; // read data register
  logic [9:0] nxt_result; // saturated result
  logic adc_tick; // one converter clock tick
  logic conv_end; // conversion completes this cycle
  logic csr_wr; // write to control/status
  logic drh_rd; // read of high result
  logic [2:0] div_max; // divide ratio, system clocks per converter clock (terminal count is one less)

  assign csr_wr = i_wr && (i_addr == `ADC_OFS_CSR);
  assign drh_rd = i_rd && (i_addr == `ADC_OFS_DRH);

  // wait mode is deliberately not decoded anywhere; conversions go on
  logic unused_wait;
  assign unused_wait = i_wait_mode;

  // control fields written by software
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      speed_ff <= 1'b0;
      converter_on_ff <= 1'b0;
      channel_select_ff <= 4'h0;
    end else if (csr_wr) begin
      speed_ff <= i_wdata[`ADC_BIT_SPEED];
      converter_on_ff <= i_wdata[`ADC_BIT_ON];
      channel_select_ff <= i_wdata[`ADC_CH_MSB:0];
    end
  end

  // converter clock divider, restarted with each conversion
  assign div_max = speed_ff ? `ADC_DIV_FAST : `ADC_DIV_SLOW;
  assign adc_tick = (state_ff == ST_CONV) && (div_cnt_ff == div_max - 3'h1);
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_cnt_ff <= 3'h0;
    end else if (csr_wr || state_ff != ST_CONV || adc_tick) begin
      div_cnt_ff <= 3'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 3'h1;
    end
  end

  // conversion ends after a fixed count of converter clocks
  assign conv_end = adc_tick && (conv_cnt_ff == `ADC_CONV_CLKS - 5'h01);

  // sequencer: off, halted, converting continuously
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= ST_OFF;
      conv_cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        ST_OFF: begin
          conv_cnt_ff <= 5'h00;
          if (converter_on_ff && !i_halt_mode) begin
            state_ff <= ST_CONV;
          end
        end
        ST_HALTED: begin
          // converter disabled in halt; settling left to software
          conv_cnt_ff <= 5'h00;
          if (!i_halt_mode) begin
            state_ff <= ST_OFF;
          end
        end
        ST_CONV: begin
          if (i_halt_mode) begin
            state_ff <= ST_HALTED;
            conv_cnt_ff <= 5'h00;
          end else if (!converter_on_ff) begin
            state_ff <= ST_OFF;
            conv_cnt_ff <= 5'h00;
          end else if (csr_wr || conv_end) begin
            // restart on any control write, or next back-to-back conversion
            conv_cnt_ff <= 5'h00;
          end else if (adc_tick) begin
            conv_cnt_ff <= conv_cnt_ff + 5'h01;
          end
        end
        default: begin
          state_ff <= ST_OFF;
          conv_cnt_ff <= 5'h00;
        end
      endcase
    end
  end

  // saturate out of range inputs without any overflow flag
  always_comb begin
    if (i_over_range) begin
      nxt_result = `ADC_RES_FULL;
    end else if (i_under_range) begin
      nxt_result = `ADC_RES_ZERO;
    end else begin
      nxt_result = i_sample;
    end
  end

  // result pair overwritten on each completion, no latching
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      result_ff <= `ADC_RES_RST;
    end else if (conv_end && !csr_wr) begin
      result_ff <= nxt_result;
    end
  end

  // done flag: completion wins over a high-result read in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      done_ff <= 1'b0;
    end else if (csr_wr) begin
      done_ff <= 1'b0; // a write aborts the conversion, so no set
    end else if (conv_end) begin
      done_ff <= 1'b1;
    end else if (drh_rd) begin
      done_ff <= 1'b0;
    end
  end

  // read data, valid the cycle after the read strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_ff <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `ADC_OFS_CSR: rdata_ff <= {done_ff, speed_ff, converter_on_ff, 1'b0, channel_select_ff};
        `ADC_OFS_DRH: rdata_ff <= result_ff[9:2];
        `ADC_OFS_DRL: rdata_ff <= {6'h00, result_ff[1:0]};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_channel_select = channel_select_ff;
  assign o_converter_on = (state_ff == ST_CONV);
  assign o_sample_strobe = (state_ff == ST_CONV) && (conv_cnt_ff == 5'h00) && (div_cnt_ff == 3'h0);

  // system clocks since the last conversion start, counted apart from the
  // divider so that the length check does not lean on the logic it checks
  logic [7:0] conv_age_ff; // clocks into the current conversion, saturating
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      conv_age_ff <= 8'h00;
    end else if (o_sample_strobe) begin
      conv_age_ff <= 8'h01; // a new conversion starts
    end else if (conv_age_ff != 8'hff) begin
      conv_age_ff <= conv_age_ff + 8'h01;
    end
  end

  // input captured at each conversion start, for the selection check
  logic [3:0] conv_ch_ff; // channel that the running conversion samples
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      conv_ch_ff <= 4'h0;
    end else if (o_sample_strobe) begin
      conv_ch_ff <= channel_select_ff;
    end
  end

  // checks

  // a control write drops the done flag
  AST_WR_CLEARS_DONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    csr_wr
    |=> !done_ff)
    else $error("done flag not cleared by control write");

  // a high result read drops the done flag unless a completion wins
  AST_DRH_CLEARS_DONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    drh_rd && !conv_end && !csr_wr
    |=> !done_ff)
    else $error("done flag not cleared by high read");

  // a completion sets done and stores the new result
  AST_DONE_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    conv_end && !csr_wr
    |=> done_ff && result_ff == $past(nxt_result))
    else $error("completion not recorded");

  // over range saturates to full scale
  AST_FULL_SCALE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    conv_end && !csr_wr && i_over_range
    |=> result_ff == 10'h3ff)
    else $error("over range not full scale");

  // under range saturates to zero
  AST_ZERO_SCALE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    conv_end && !csr_wr && !i_over_range && i_under_range
    |=> result_ff == 10'h000)
    else $error("under range not zero");

  // an idle converter stays idle while switched off
  AST_OFF_STOPS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !converter_on_ff && state_ff == ST_OFF
    |=> !o_converter_on)
    else $error("converter runs while off");

  // halt stops the converter on the next edge
  AST_HALT_STOPS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_halt_mode
    |=> state_ff != ST_CONV)
    else $error("converter runs in halt");

  // a control write during conversion restarts it from the beginning
  AST_RESTART: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    csr_wr && state_ff == ST_CONV && converter_on_ff && !i_halt_mode
    |=> conv_cnt_ff == 5'h00 && div_cnt_ff == 3'h0)
    else $error("control write did not restart conversion");

  // low result read: upper bits zero, low bits as they stood at the read
  AST_DRL_UPPER_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rd && i_addr == `ADC_OFS_DRL
    |=> o_rdata[7:2] == 6'h00 && o_rdata[1:0] == $past(result_ff[1:0]))
    else $error("low result upper bits not zero");

  // completion only on the last converter clock
  AST_CONV_LEN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    conv_end
    |-> conv_cnt_ff == 5'h0d)
    else $error("conversion length wrong");

  // conversion length in system clocks follows the speed bit
  AST_CONV_CLOCKS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    conv_end
    |-> conv_age_ff == ({3'h0, `ADC_CONV_CLKS} * {5'h00, div_max}) - 8'h01)
    else $error("conversion clocks wrong for speed setting");

  // a conversion ends on the input it started on
  AST_CONV_INPUT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    conv_end
    |-> o_channel_select == conv_ch_ff)
    else $error("conversion input changed underway");

  // read data is zero outside the answer cycle
  AST_RDATA_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_rd
    |=> o_rdata == 8'h00)
    else $error("read data not idle zero");

  // high result read returns bits 9..2 as they stood at the read
  AST_DRH_DATA: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rd && i_addr == `ADC_OFS_DRH
    |=> o_rdata == $past(result_ff[9:2]))
    else $error("high result read wrong");

  // control read: reserved bit zero, channel and done as stored
  AST_CSR_READ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rd && i_addr == `ADC_OFS_CSR
    |=> !o_rdata[4] && o_rdata[3:0] == $past(channel_select_ff) && o_rdata[7] == $past(done_ff))
    else $error("control read wrong");

  // the written channel field drives the input select
  AST_CHANNEL_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    csr_wr
    |=> o_channel_select == $past(i_wdata[3:0]))
    else $error("channel select not taken from write");

  // switching on starts conversion within two edges outside halt
  AST_ON_FROM_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    csr_wr && i_wdata[`ADC_BIT_ON] && !i_halt_mode ##1 !i_halt_mode
    |=> o_converter_on)
    else $error("converter not started by on bit");

  // switching off stops conversion within two edges
  AST_OFF_FROM_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    csr_wr && !i_wdata[`ADC_BIT_ON]
    |=> ##1 !o_converter_on)
    else $error("converter not stopped by off bit");

  // results change only on a completion
  AST_RESULT_HOLDS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !(conv_end && !csr_wr)
    |=> result_ff == $past(result_ff))
    else $error("result changed without completion");

  // done stays up until a write or a high read
  AST_DONE_HOLDS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    done_ff && !csr_wr && !drh_rd
    |=> done_ff)
    else $error("done flag lost");

  // done never rises without a completion
  AST_NO_SPURIOUS_DONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !done_ff && !conv_end
    |=> !done_ff)
    else $error("done flag set without completion");

  // the converter stays down while halt lasts
  AST_HALT_STAYS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_ff == ST_HALTED && i_halt_mode
    |=> state_ff == ST_HALTED && !o_converter_on)
    else $error("converter left halt early");

  // a channel change stops, clears done and restarts
  AST_CH_CHANGE_CLEARS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    csr_wr && i_wdata[3:0] != channel_select_ff && state_ff == ST_CONV && converter_on_ff && !i_halt_mode
    |=> !done_ff && conv_cnt_ff == 5'h00 && div_cnt_ff == 3'h0)
    else $error("channel change did not restart");

  // wait mode leaves a running conversion running
  AST_WAIT_NO_EFFECT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_wait_mode && !i_halt_mode && state_ff == ST_CONV && converter_on_ff
    |=> state_ff == ST_CONV)
    else $error("wait mode stopped the converter");
endmodule : adc_conversion_control
`default_nettype wire

// ==== verification/analog_side_model.sv ====
/*
  model of the analog side: a code for each input and range flags.
  assumes: channel comes from the block, range requests from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module analog_side_model (
  // from the block
  input wire logic [3:0] i_channel_select,
  // range requests
  input wire logic i_over,
  input wire logic i_under,
  // to the block
  output logic [9:0] o_sample,
  output logic o_over_range,
  output logic o_under_range
);
  // each input has its own code, so a wrong input shows
  assign o_sample = {i_channel_select, 6'h2d};
  // range flags follow the bench
  assign o_over_range = i_over;
  assign o_under_range = i_under;
endmodule : analog_side_model
`default_nettype wire

// ==== verification/adc_conversion_control_tb_top.sv ====
/*
  bench for the converter control block: scenario tasks over the register port.
  assumes: the analog side model and the design are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_cfg.svh"
module adc_conversion_control_tb_top;
  import adc_ctl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, halt = 1'b0, wt = 1'b0, ovr_q = 1'b0, und_q = 1'b0;
  reg_addr_t addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [9:0] sample;
  logic [3:0] ch;
  logic ovr, und, on, strb;
  int n_mismatch = 0, n_compared = 0;
  // free running clock
  initial forever #5 clk = ~clk;
  adc_conversion_control i_adc_conversion_control (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_halt_mode(halt), .i_wait_mode(wt), .i_sample(sample),
    .i_over_range(ovr), .i_under_range(und), .o_channel_select(ch), .o_converter_on(on), .o_sample_strobe(strb));
  analog_side_model i_analog_side_model (.i_channel_select(ch), .i_over(ovr_q), .i_under(und_q),
    .o_sample(sample), .o_over_range(ovr), .o_under_range(und));
  // byte compare
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // one cycle write
  task automatic wr_reg(input reg_addr_t a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // one cycle read, data taken in the following cycle
  task automatic rd_reg(input reg_addr_t a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // poll the done flag under a bound
  task automatic wait_done();
    logic [7:0] v = 8'h00;
    for (int i = 0; i < 100 && v[7] !== 1'b1; i++) rd_reg(2'h0, v);
    chk("done flag", 8'h80, v & 8'h80);
  endtask : wait_done
  // low then high, then done must be gone
  task automatic rd_pair(input logic [9:0] exp);
    logic [7:0] v;
    rd_reg(2'h2, v);
    chk("result low", {6'h00, exp[1:0]}, v);
    rd_reg(2'h1, v);
    chk("result high", exp[9:2], v);
    rd_reg(2'h0, v);
    chk("done after high read", 8'h00, v & 8'h80);
  endtask : rd_pair
  // cycles between two conversion starts
  task automatic gap(output int n);
    n = 0;
    for (int i = 0; i < 300 && strb !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    do begin
      @(posedge clk);
      #1 n++;
    end while (n < 300 && strb !== 1'b1);
  endtask : gap
  // all places read zero after reset, the unmapped one too
  task automatic t_reset();
    logic [7:0] v;
    for (int a = 0; a < 4; a++) begin
      rd_reg(a[1:0], v);
      chk("reset value", 8'h00, v);
    end
    $display("test reset done");
  endtask : t_reset
  // switch on, read a result, see conversion continue
  task automatic t_convert();
    wr_reg(2'h0, 8'h23);
    repeat (3) @(posedge clk);
    #1 chk("converter on", 8'h01, {7'h00, on});
    wait_done();
    rd_pair({4'h3, 6'h2d});
    wait_done();
    $display("test convert done");
  endtask : t_convert
  // restarts, saturation and channel change
  task automatic t_restart();
    logic [7:0] v;
    ovr_q <= 1'b1;
    wr_reg(2'h0, 8'h33);
    rd_reg(2'h0, v);
    chk("control readback", 8'h23, v);
    wait_done();
    rd_pair(`ADC_RES_FULL);
    ovr_q <= 1'b0;
    und_q <= 1'b1;
    wr_reg(2'h0, 8'h23);
    wait_done();
    rd_pair(`ADC_RES_ZERO);
    und_q <= 1'b0;
    wait_done();
    wr_reg(2'h0, 8'h2c);
    rd_reg(2'h0, v);
    chk("done after channel change", 8'h2c, v);
    chk("channel select", 8'h0c, {4'h0, ch});
    wait_done();
    rd_pair({4'hc, 6'h2d});
    $display("test restart done");
  endtask : t_restart
  // the speed bit halves the conversion time
  task automatic t_speed();
    int n4, n2;
    wr_reg(2'h0, 8'h23);
    gap(n4);
    wr_reg(2'h0, 8'h63);
    gap(n2);
    chk("speed gap", 8'(2 * `ADC_CONV_CLKS), 8'(n4 - n2));
    chk("slow period", 8'(int'(`ADC_DIV_SLOW) * `ADC_CONV_CLKS), 8'(n4));
    chk("fast period", 8'(int'(`ADC_DIV_FAST) * `ADC_CONV_CLKS), 8'(n2));
    $display("test speed done");
  endtask : t_speed
  // wait, halt and switch off
  task automatic t_modes();
    logic [7:0] v;
    wr_reg(2'h0, 8'h23);
    wt <= 1'b1;
    wait_done();
    wt <= 1'b0;
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("on in halt", 8'h00, {7'h00, on});
    halt <= 1'b0;
    wr_reg(2'h0, 8'h03);
    repeat (3) @(posedge clk);
    #1 chk("on when off", 8'h00, {7'h00, on});
    repeat (80) @(posedge clk);
    rd_reg(2'h0, v);
    chk("no done when off", 8'h03, v);
    $display("test modes done");
  endtask : t_modes
  // verdict and end of run
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_convert();
    t_restart();
    t_speed();
    t_modes();
    test_done();
  end
  // watchdog against a hang
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule : adc_conversion_control_tb_top
`default_nettype wire
